/* File: common/adcs_pkg.sv */
/*
  constants and types shared by the conversion sequencer and its
  bit period generator: register indices, field positions, reset values,
  clock select codes and conversion timing counts.
  assumes a 50 MHz core clock that is also the converter's oscillator.
*/
package adcs_pkg;
  // register indices; the byte address on the bus is four times the index
  localparam logic [7:0] IDX_PORT = 8'h05;
  localparam logic [7:0] IDX_INTCTL = 8'h0b;
  localparam logic [7:0] IDX_IRQ_FLAGS = 8'h0c;
  localparam logic [7:0] IDX_RESULT = 8'h1e;
  localparam logic [7:0] IDX_CTL = 8'h1f;
  localparam logic [7:0] IDX_DIR = 8'h85;
  localparam logic [7:0] IDX_IRQ_EN = 8'h8c;
  localparam logic [7:0] IDX_CFG = 8'h9f;
  // converter_control field positions
  localparam int CTL_ON = 0;
  localparam int CTL_GO = 2;
  localparam int CTL_CHS_LO = 3;
  localparam int CTL_CS_LO = 6;
  // conv_done_irq_flag / conv_done_irq_enable position
  localparam int IRQ_DONE = 6;
  // implemented bits of the flag and enable registers
  localparam logic [7:0] IRQ_MASK = 8'h4f;
  // reset values
  localparam logic [7:0] INTCTL_RST = 8'h00;
  localparam logic [7:0] IRQ_RST = 8'h00;
  localparam logic [5:0] DIR_RST = 6'h3f;
  localparam logic [2:0] CFG_RST = 3'h0;
  // compare_mode_field value that routes the special event here
  localparam logic [3:0] SPECIAL_EVT_MODE = 4'hb;
  // oscillator periods per conv_bit_period for each divided source
  localparam int OSC_PER_TAD_2 = 2;
  localparam int OSC_PER_TAD_8 = 8;
  localparam int OSC_PER_TAD_32 = 32;
  // half bit periods per conversion: 9.5 bit periods
  localparam int CONV_HALF_TADS = 19;
  localparam logic [4:0] HALF_LAST = 5'(CONV_HALF_TADS - 1);
  // conv_clock_select encoding
  typedef enum logic [1:0] {CS_DIV2, CS_DIV8, CS_DIV32, CS_RC} adcs_clk_sel_t;
  // conversion sequencer states
  typedef enum logic {CV_IDLE, CV_RUN} adcs_conv_st_t;
endpackage : adcs_pkg

/* File: tb/adcs_far_side.sv */
/*
  far side of the conversion sequencer: hold capacitor, comparator and the
  internal rc oscillator, all behavioural.
  assumes the bench sets the analog level and watches the core clock itself.
*/
`timescale 1ns/1ns
module adcs_far_side (
  input wire logic [7:0] level,
  input wire logic [7:0] dac_code,
  input wire logic hold_connect,
  output logic comp_above,
  output logic rc_osc
);
  logic [7:0] held = 8'h00; // charge on the hold capacitor
  // capacitor tracks the pin only while connected, so a late disconnect shows up
  always @(level or hold_connect) begin
    if (hold_connect === 1'b1) begin
      held = level;
    end
  end
  // comparator: high while the held level reaches the trial code
  assign comp_above = (held >= dac_code);
  // free running, phase unrelated to the core clock, keeps going in sleep
  initial begin
    rc_osc = 1'b0;
    forever #1990 rc_osc = ~rc_osc;
  end
endmodule : adcs_far_side

/* File: tb/tb_top.sv */
/*
  self-checking bench for the conversion sequencer: wishbone register
  traffic, every clock source, trigger, abort, reset and port readback.
  assumes a 50 MHz core clock and the far side model beside the design.
*/
`timescale 1ns/1ns
module tb_top;
  logic clk = 0, nrst = 0, cyc = 0, stb = 0, we = 0, sleep = 0, evt = 0;
  logic [3:0] sel = 4'hf;
  logic [3:0] mode = 4'h0;
  logic [9:0] adr = 10'h000;
  logic [31:0] dat = 32'h0, dat_o;
  logic [5:0] pins = 6'h2a;
  logic [7:0] level = 8'h5a, dac, last;
  logic ack, above, rc, hold, pwr, tclr;
  logic [2:0] chsel;
  int num_errors = 0, total_checks = 0, tc_cnt = 0, tc, n;
  logic [7:0] expq[$]; // expected read data, oldest first
  localparam int ACQ = 700; // 14us at 50 MHz: acquisition and two rc bit periods

  always #10 clk = ~clk;

  adcs_sequencer u_adcs_sequencer (.CORE_CLK(clk), .NRST(nrst), .CYC_I(cyc), .STB_I(stb), .WE_I(we),
    .SEL_I(sel), .ADR_I(adr), .DAT_I(dat), .DAT_O(dat_o), .ACK_O(ack), .PIN_LEVELS(pins),
    .COMP_ABOVE(above), .RC_OSC(rc), .SLEEP(sleep), .COMPARE_MODE(mode), .SPECIAL_EVENT(evt),
    .DAC_CODE(dac), .CHANNEL_SEL(chsel), .HOLD_CAP_CONNECT(hold), .CONVERTER_POWERED(pwr),
    .TIMER_CLEAR(tclr));
  adcs_far_side u_adcs_far_side (.level(level), .dac_code(dac), .hold_connect(hold),
    .comp_above(above), .rc_osc(rc));

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one classic cycle; a read notes its expected byte for the monitor
  task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    if (!w) expq.push_back(d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {idx, 2'b00};
    dat <= {24'h0, d};
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb

  // monitor: read data is taken at the edge where ack is sampled high
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (expq.size() == 0) chk(dat_o[7:0], 8'hxx);
      else chk(dat_o[7:0], expq.pop_front());
    end
  end
  always @(posedge clk) if (tclr === 1'b1) tc_cnt++;

  // counts cycles with the capacitor disconnected; zero if none starts
  task automatic wait_done(output int cnt);
    cnt = 0;
    for (int i = 0; i < 4 && hold === 1'b1; i++) @(negedge clk);
    while (hold !== 1'b1) begin
      cnt++;
      @(negedge clk);
    end
  endtask : wait_done

  task automatic pulse();
    @(posedge clk);
    evt <= 1'b1;
    @(posedge clk);
    evt <= 1'b0;
  endtask : pulse

  task automatic conv(input logic [1:0] cs);
    int d, lo, hi;
    d = (cs == 2'd0) ? 1 : (cs == 2'd1) ? adcs_pkg::OSC_PER_TAD_8 / 2 : adcs_pkg::OSC_PER_TAD_32 / 2;
    lo = (cs == 2'd3) ? 1780 : 19 * d - 2;
    hi = (cs == 2'd3) ? 2000 : 19 * d + 2;
    wb(1, adcs_pkg::IDX_CTL, {cs, 1'b0, cs, 3'b001});
    repeat (ACQ) @(posedge clk); // acquisition and gap between conversions
    wb(1, adcs_pkg::IDX_CTL, {cs, 1'b0, cs, 3'b101});
    wait_done(n);
    chk({7'h0, n >= lo && n <= hi}, 8'h01);
    chk({pwr, 4'h0, chsel}, {1'b1, 5'h0, cs});
    chk(dac, level);
    wb(0, adcs_pkg::IDX_RESULT, level);
    wb(0, adcs_pkg::IDX_IRQ_FLAGS, 8'h40);
    wb(0, adcs_pkg::IDX_CTL, {cs, 1'b0, cs, 3'b001});
    wb(1, adcs_pkg::IDX_IRQ_FLAGS, 8'h00);
  endtask : conv

  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  initial begin
    // the tests take about 8,000 cycles; 20,000 is ample
    #400000;
    num_errors++;
    $display("ERROR %0t: watchdog expired", $time);
    finish_test();
  end

  initial begin
    void'($urandom(32'hfa83764f));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    // reset values and an unmapped place
    wb(0, adcs_pkg::IDX_CTL, 8'h00);
    wb(0, adcs_pkg::IDX_DIR, 8'h3f);
    wb(0, adcs_pkg::IDX_IRQ_FLAGS, 8'h00);
    wb(0, adcs_pkg::IDX_CFG, 8'h00);
    wb(0, 8'h40, 8'h00);
    wb(1, adcs_pkg::IDX_IRQ_EN, 8'hff);
    wb(0, adcs_pkg::IDX_IRQ_EN, adcs_pkg::IRQ_MASK);
    $display("test registers done");
    // go in the same write that powers up is ignored
    wb(1, adcs_pkg::IDX_CTL, 8'h05);
    wait_done(n);
    chk(n[7:0], 8'h00);
    wb(0, adcs_pkg::IDX_CTL, 8'h01);
    $display("test early go done");
    // every clock source, rc one asleep
    for (int cs = 0; cs < 4; cs++) begin
      level <= 8'($urandom);
      sleep <= (cs == 3); // rc only while asleep
      conv(cs[1:0]); // only rc meets the minimum bit period at this clock
    end
    sleep <= 1'b0;
    $display("test clock sources done");
    // special event: on, wrong mode, off
    tc = tc_cnt;
    level <= 8'($urandom);
    mode <= adcs_pkg::SPECIAL_EVT_MODE;
    wb(1, adcs_pkg::IDX_CTL, 8'h01);
    repeat (ACQ) @(posedge clk);
    pulse();
    wait_done(n);
    chk({7'h0, n >= 17 && n <= 21}, 8'h01);
    wb(0, adcs_pkg::IDX_RESULT, level);
    wb(1, adcs_pkg::IDX_IRQ_FLAGS, 8'h00);
    chk(8'(tc_cnt - tc), 8'h01);
    mode <= 4'h0;
    pulse();
    wait_done(n);
    chk(n[7:0], 8'h00);
    mode <= adcs_pkg::SPECIAL_EVT_MODE;
    wb(1, adcs_pkg::IDX_CTL, 8'h00);
    pulse();
    wait_done(n);
    chk(n[7:0], 8'h00);
    chk(8'(tc_cnt - tc), 8'h02);
    $display("test trigger done");
    // abort by clearing go keeps result and flag
    last = level;
    level <= ~level;
    wb(1, adcs_pkg::IDX_CTL, 8'h01);
    repeat (ACQ) @(posedge clk);
    wb(1, adcs_pkg::IDX_CTL, 8'h05);
    // divided source frozen by sleep before the abort
    sleep <= 1'b1;
    repeat (5) @(posedge clk);
    sleep <= 1'b0;
    wb(1, adcs_pkg::IDX_CTL, 8'h01);
    wait_done(n);
    chk({7'h0, n < 3}, 8'h01);
    wb(0, adcs_pkg::IDX_RESULT, last);
    wb(0, adcs_pkg::IDX_IRQ_FLAGS, 8'h00);
    // reset in mid conversion
    repeat (ACQ) @(posedge clk);
    wb(1, adcs_pkg::IDX_CTL, 8'h05);
    repeat (5) @(posedge clk);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    chk({6'h0, hold, pwr}, 8'h02);
    wb(0, adcs_pkg::IDX_CTL, 8'h00);
    $display("test abort done");
    // port readback with analog pins forced low
    pins <= 6'($urandom);
    wb(1, adcs_pkg::IDX_CFG, 8'h00);
    wb(0, adcs_pkg::IDX_PORT, {2'b00, pins & 6'h10});
    wb(1, adcs_pkg::IDX_CFG, 8'h04);
    wb(0, adcs_pkg::IDX_PORT, {2'b00, pins & 6'h34});
    wb(1, adcs_pkg::IDX_CFG, 8'h06);
    wb(0, adcs_pkg::IDX_PORT, {2'b00, pins});
    $display("test port done");
    repeat (4) @(posedge clk);
    finish_test();
  end
endmodule : tb_top

/* File: verilog/adcs_sequencer.sv */
/*
  conversion sequencer for an 8-bit successive approximation converter:
  classic wishbone register slave, go flag and special event start,
  bit-by-bit approximation, result and done flag, port readback masking.
  assumes the comparator, dac and hold switch sit outside this block, that
  pins and rc oscillator are asynchronous to CORE_CLK, and that the
  comparator settles within one core cycle of a DAC_CODE change.
  // Contract
  // [R1] one conversion takes 9.5 bit periods
  // [R2] four bit period sources selectable
  // [R3] select 00 /2, 01 /8, 10 /32, 11 rc
  // [R4] software keeps bit period at least 1.6us
  // [R5] rc source independent of core clock
  // [R6] conversion continues in sleep with rc
  // [R7] above 1 MHz rc only for sleep
  // [R8] software waits acquisition time before start
  // [R9] hold capacitor disconnected during conversion
  // [R10] analog pins read as zero
  // [R11] pin sampled whatever its direction
  // [R12] start not gated by channel or direction
  // [R13] switch on before setting go
  // [R14] special event starts conversion, clears timer
  // [R15] converter off: event only clears timer
  // [R16] done loads result, clears go, sets flag
  // [R17] reset turns off and aborts
  // [R18] software waits two bit periods between
  // [R19] go write ignored while converter off
  // [R20] clearing go aborts, result and flag kept
*/
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ns
module adcs_sequencer (
  input wire logic CORE_CLK,
  input wire logic NRST,
  input wire logic CYC_I,
  input wire logic STB_I,
  input wire logic WE_I,
  input wire logic [3:0] SEL_I,
  input wire logic [9:0] ADR_I,
  input wire logic [31:0] DAT_I,
  output logic [31:0] DAT_O,
  output logic ACK_O,
  input wire logic [5:0] PIN_LEVELS,
  input wire logic COMP_ABOVE,
  input wire logic RC_OSC,
  input wire logic SLEEP,
  input wire logic [3:0] COMPARE_MODE,
  input wire logic SPECIAL_EVENT,
  output logic [7:0] DAC_CODE,
  output logic [2:0] CHANNEL_SEL,
  output logic HOLD_CAP_CONNECT,
  output logic CONVERTER_POWERED,
  output logic TIMER_CLEAR
);
  // all state of the sequencer
  typedef struct packed {
    logic ack; // bus answer
    logic [7:0] rdat; // captured read data
    logic [5:0] pin_m; // pin synchroniser, first stage
    logic [5:0] pin_s; // pin synchroniser, second stage
    logic [7:0] intctl; // global_interrupt_control, storage only
    logic [7:0] irqf; // peripheral_irq_flags
    logic [7:0] irqe; // peripheral_irq_enables
    logic [7:0] res; // conversion_result
    adcs_pkg::adcs_clk_sel_t cs; // conv_clock_select
    logic [2:0] chs; // input_channel_select
    logic go; // go flag
    logic on; // converter_on
    logic [5:0] dir; // pin_direction_bits
    logic [2:0] cfg; // port_analog_config_field
    adcs_pkg::adcs_conv_st_t st; // sequencer state
    logic [4:0] half; // half bit periods elapsed
    logic [7:0] sar; // approximation register
    logic tclr; // timer clear pulse
  } adcs_state_t;

  adcs_state_t r;
  adcs_state_t n;
  logic req; // bus request present
  logic wr; // write takes effect this edge
  logic [7:0] idx; // register index from the byte address
  logic busy; // conversion running
  logic spec_trig; // special event routed to this block
  logic half_tick; // half bit period pulse
  logic sw_go; // software go write, accepted
  logic sw_stop; // software clears go or turns off
  logic done; // last half period of a conversion
  logic [2:0] bit_idx; // approximation bit under test

  // pins set as analog inputs or reference, per port_analog_config_field
  function automatic logic [5:0] analog_mask(input logic [2:0] cfg);
    if (cfg[2:1] == 2'b11) begin
      analog_mask = 6'h00; // all digital
    end else if (cfg[2]) begin
      analog_mask = 6'h0b; // pins 0, 1, 3
    end else begin
      analog_mask = 6'h2f; // pins 0-3 and 5
    end
  endfunction : analog_mask

  // bit period source
  adcs_tad_gen u_tad (
    .clk(CORE_CLK),
    .nrst(NRST),
    .rc_osc(RC_OSC),
    .sel(r.cs),
    .sleep(SLEEP),
    .run(busy),
    .half_tick(half_tick)
  );

  // next state: bus, registers, conversion
  always_comb begin
    n = r;
    n.pin_m = PIN_LEVELS;
    n.pin_s = r.pin_m;
    req = CYC_I && STB_I;
    idx = ADR_I[9:2];
    busy = (r.st == adcs_pkg::CV_RUN);
    // a write lands on the edge where the master sees ack
    wr = req && WE_I && r.ack && SEL_I[0];
    n.ack = req && !r.ack;
    sw_go = 1'b0;
    sw_stop = 1'b0;
    // read data is captured on the same edge that raises ack
    if (req && !r.ack) begin
      case (idx)
        adcs_pkg::IDX_PORT: n.rdat = {2'b00, r.pin_s & ~analog_mask(r.cfg)}; // [R10]
        adcs_pkg::IDX_INTCTL: n.rdat = r.intctl;
        adcs_pkg::IDX_IRQ_FLAGS: n.rdat = r.irqf;
        adcs_pkg::IDX_IRQ_EN: n.rdat = r.irqe;
        adcs_pkg::IDX_RESULT: n.rdat = r.res;
        adcs_pkg::IDX_CTL: n.rdat = {r.cs, r.chs, r.go, 1'b0, r.on};
        adcs_pkg::IDX_DIR: n.rdat = {2'b00, r.dir};
        adcs_pkg::IDX_CFG: n.rdat = {5'h00, r.cfg};
        default: n.rdat = 8'h00; // unmapped reads zero
      endcase
    end
    // register writes; unmapped writes are acked and dropped
    if (wr) begin
      case (idx)
        adcs_pkg::IDX_INTCTL: n.intctl = DAT_I[7:0];
        adcs_pkg::IDX_IRQ_FLAGS: n.irqf = DAT_I[7:0] & adcs_pkg::IRQ_MASK;
        adcs_pkg::IDX_IRQ_EN: n.irqe = DAT_I[7:0] & adcs_pkg::IRQ_MASK;
        adcs_pkg::IDX_CTL: begin
          n.cs = adcs_pkg::adcs_clk_sel_t'(DAT_I[adcs_pkg::CTL_CS_LO +: 2]);
          n.chs = DAT_I[adcs_pkg::CTL_CHS_LO +: 3];
          n.on = DAT_I[adcs_pkg::CTL_ON];
          // go counts only if the converter was already on [R19]
          sw_go = DAT_I[adcs_pkg::CTL_GO] && DAT_I[adcs_pkg::CTL_ON] && r.on; // [R12]
          sw_stop = !DAT_I[adcs_pkg::CTL_GO] || !DAT_I[adcs_pkg::CTL_ON];
          if (sw_stop) begin
            n.go = 1'b0;
          end
        end
        adcs_pkg::IDX_DIR: n.dir = DAT_I[5:0];
        adcs_pkg::IDX_CFG: n.cfg = DAT_I[2:0];
        default: ;
      endcase
    end
    // the timer is cleared whether or not the converter is on [R14] [R15]
    spec_trig = SPECIAL_EVENT && (COMPARE_MODE == adcs_pkg::SPECIAL_EVT_MODE);
    n.tclr = spec_trig;
    done = busy && half_tick && (r.half == adcs_pkg::HALF_LAST); // [R1]
    bit_idx = 3'(3'd7 - r.half[3:1]);
    unique case (r.st)
      adcs_pkg::CV_IDLE: begin
        // trigger ignored while off; wins over a same-cycle clear [R14] [R15]
        if (sw_go || (spec_trig && r.on)) begin
          n.go = 1'b1;
          n.st = adcs_pkg::CV_RUN;
          n.half = 5'h00;
          n.sar = 8'h80;
        end
      end
      adcs_pkg::CV_RUN: begin
        if (sw_stop) begin
          // abort: result and flag untouched [R20]
          n.st = adcs_pkg::CV_IDLE;
        end else if (done) begin
          // completion; the flag set wins over a same-cycle clear [R16]
          n.res = r.sar;
          n.go = 1'b0;
          n.irqf[adcs_pkg::IRQ_DONE] = 1'b1;
          n.st = adcs_pkg::CV_IDLE;
        end else if (half_tick) begin
          n.half = r.half + 5'h01;
          // decide one bit at the end of each of the first 8 periods
          if (r.half[0] && !r.half[4]) begin
            // comparator read directly: it follows DAC_CODE against a frozen
            // hold level, and two synchroniser stages would outlast a /2 half period
            n.sar[bit_idx] = COMP_ABOVE;
            if (bit_idx != 3'h0) begin
              n.sar[bit_idx - 3'h1] = 1'b1;
            end
          end
        end
      end
    endcase
  end

  // register the state; reset turns off and aborts [R17]
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      r <= '0;
      r.dir <= adcs_pkg::DIR_RST;
      r.cfg <= adcs_pkg::CFG_RST;
      r.irqf <= adcs_pkg::IRQ_RST;
      r.irqe <= adcs_pkg::IRQ_RST;
      r.intctl <= adcs_pkg::INTCTL_RST;
    end else begin
      r <= n;
    end
  end

  // outputs
  assign DAT_O = {24'h000000, r.rdat};
  assign ACK_O = r.ack;
  assign DAC_CODE = r.sar;
  // channel passes straight through; direction never gates it [R11]
  assign CHANNEL_SEL = r.chs;
  // hold switch opens for the whole conversion [R9]
  assign HOLD_CAP_CONNECT = !busy;
  assign CONVERTER_POWERED = r.on;
  assign TIMER_CLEAR = r.tclr;

  // assertion helper: cycles since start, and whether sleep was seen
  logic [5:0] run_cyc;
  logic slept;
  always_ff @(posedge CORE_CLK) begin
    if (!NRST || !busy) begin
      run_cyc <= 6'h00;
      slept <= 1'b0;
    end else begin
      run_cyc <= run_cyc + 6'h01;
      slept <= slept || SLEEP;
    end
  end

  default clocking dcb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  property p_div2_length;
    done && r.cs == adcs_pkg::CS_DIV2 && !slept && !SLEEP |-> run_cyc == 6'd18;
  endproperty
  a_div2_length: assert property (p_div2_length) else $error("div2 conversion not 19 cycles"); // [R1]

  property p_start_needs_on;
    $rose(busy) |-> $past(r.on);
  endproperty
  a_start_needs_on: assert property (p_start_needs_on) else $error("conversion started while off"); // [R19]

  property p_sw_go_starts;
    !busy && wr && idx == adcs_pkg::IDX_CTL && DAT_I[2] && DAT_I[0] && r.on |=> busy && r.go;
  endproperty
  a_sw_go_starts: assert property (p_sw_go_starts) else $error("go write did not start"); // [R12]

  property p_trig_starts;
    !busy && spec_trig && r.on && !(wr && idx == adcs_pkg::IDX_CTL) |=> busy ##0 TIMER_CLEAR;
  endproperty
  a_trig_starts: assert property (p_trig_starts) else $error("special event did not start"); // [R14]

  property p_trig_off;
    !busy && spec_trig && !r.on |=> !busy && TIMER_CLEAR;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("special event misused while off"); // [R15]

  property p_done_effects;
    done |=> !busy && !r.go && r.irqf[adcs_pkg::IRQ_DONE] && r.res == $past(r.sar);
  endproperty
  a_done_effects: assert property (p_done_effects) else $error("completion effects missing"); // [R16]

  property p_abort;
    busy && wr && idx == adcs_pkg::IDX_CTL && !DAT_I[2] |=> !busy && $stable(r.res)
      && $stable(r.irqf[adcs_pkg::IRQ_DONE]);
  endproperty
  a_abort: assert property (p_abort) else $error("abort changed result or flag"); // [R20]

  property p_hold_open;
    busy |-> !HOLD_CAP_CONNECT;
  endproperty
  a_hold_open: assert property (p_hold_open) else $error("hold switch closed in conversion"); // [R9]

  property p_port_zero;
    ACK_O && !WE_I && idx == adcs_pkg::IDX_PORT |-> (DAT_O[5:0] & analog_mask(r.cfg)) == 6'h00;
  endproperty
  a_port_zero: assert property (p_port_zero) else $error("analog pin read nonzero"); // [R10]

  property p_reset_off;
    $rose(NRST) |-> !r.on && !busy && !r.go;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("converter live after reset"); // [R17]

  property p_dac_start;
    $rose(busy) |-> DAC_CODE == 8'h80;
  endproperty
  a_dac_start: assert property (p_dac_start) else $error("first trial code wrong"); // [R1]

  property p_tclr_only_evt;
    TIMER_CLEAR |-> $past(SPECIAL_EVENT) && $past(COMPARE_MODE) == adcs_pkg::SPECIAL_EVT_MODE;
  endproperty
  a_tclr_only_evt: assert property (p_tclr_only_evt) else $error("timer clear without event"); // [R14]
endmodule : adcs_sequencer

/* File: verilog/adcs_tad_gen.sv */
/*
  bit period generator: emits one pulse per half conv_bit_period, from the
  core clock divided down or from the internal_rc_clock pin.
  assumes the rc oscillator pin is asynchronous to the core clock.
*/
`timescale 1ns/1ns
module adcs_tad_gen (
  input wire logic clk,
  input wire logic nrst,
  input wire logic rc_osc,
  input wire adcs_pkg::adcs_clk_sel_t sel,
  input wire logic sleep,
  input wire logic run,
  output logic half_tick
);
  // all generator state
  typedef struct packed {
    logic rc_m; // first synchroniser stage
    logic rc_s; // second synchroniser stage
    logic rc_d; // delayed copy for edge detect
    logic [3:0] cnt; // core clocks left in this half period
  } adcs_tad_t;

  adcs_tad_t r;
  adcs_tad_t n;
  logic [3:0] reload; // half period length minus one
  logic rc_edge; // either edge of the rc oscillator

  // next state and tick
  always_comb begin
    n = r;
    n.rc_m = rc_osc;
    n.rc_s = r.rc_m;
    n.rc_d = r.rc_s;
    rc_edge = r.rc_s ^ r.rc_d;
    unique case (sel) // [R3]
      adcs_pkg::CS_DIV2: reload = 4'(adcs_pkg::OSC_PER_TAD_2 / 2 - 1);
      adcs_pkg::CS_DIV8: reload = 4'(adcs_pkg::OSC_PER_TAD_8 / 2 - 1);
      adcs_pkg::CS_DIV32: reload = 4'(adcs_pkg::OSC_PER_TAD_32 / 2 - 1);
      adcs_pkg::CS_RC: reload = 4'h0;
    endcase
    half_tick = 1'b0;
    if (!run) begin
      // restart the divided count so its first half period is full length
      n.cnt = reload;
    end else if (sel == adcs_pkg::CS_RC) begin
      // rc source runs on regardless of the core and of sleep [R5] [R6]
      half_tick = rc_edge; // [R2]
    end else if (!sleep) begin
      // divided sources stop with the core oscillator in sleep [R6]
      half_tick = (r.cnt == 4'h0); // [R2]
      n.cnt = half_tick ? reload : r.cnt - 4'h1;
    end
  end

  // register the state
  always_ff @(posedge clk) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  property p_div8_spacing;
    run && sel == adcs_pkg::CS_DIV8 && !sleep && half_tick ##1
      (run && sel == adcs_pkg::CS_DIV8 && !sleep)[*4]
      |-> !$past(half_tick, 3) && !$past(half_tick, 2) && !$past(half_tick) && half_tick;
  endproperty
  a_div8_spacing: assert property (p_div8_spacing) else $error("div8 half tick spacing wrong"); // [R3]

  property p_sleep_stops_div;
    sleep && sel != adcs_pkg::CS_RC |-> !half_tick;
  endproperty
  a_sleep_stops_div: assert property (p_sleep_stops_div) else $error("divided tick in sleep"); // [R6]

  property p_rc_edges_only;
    run && sel == adcs_pkg::CS_RC && (r.rc_s == r.rc_d) |-> !half_tick;
  endproperty
  a_rc_edges_only: assert property (p_rc_edges_only) else $error("rc tick without rc edge"); // [R5]
endmodule : adcs_tad_gen
